/* sbl_boot_loader.sv */
// Purpose: serial bootstrap loader core of a 16-bit controller
// Assumes: strap and start-up pins are asynchronous to sys_clk
// Notes:   cpu side reads the forced configuration from outputs
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sbl_boot_loader
	import sbl_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'hA5, // arbitrary value
	parameter bit HAS_FLASH = 1'b1 // variant with internal flash
) (
	input wire logic sys_clk, // 25 MHz core clock
	input wire logic resetn, // hardware reset, low
	input wire logic boot_select_strap, // strap pin, low selects loader
	input wire logic external_access_strap, // strap pin, low = external
	input wire logic [15:0] startup_cfg, // start-up config pins
	input wire logic serial_receive_line, // receive pin
	input wire logic [23:0] mem_addr, // cpu access address
	input wire logic mem_fetch, // access is an instruction fetch
	input wire logic ram_wr_ready, // internal ram accepts a byte
	input wire logic [1:0] reg_addr, // register index
	input wire logic [15:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [15:0] reg_rdata, // read data, cycle after strobe
	output logic serial_transmit_pin, // transmit pin level
	output logic transmit_pin_direction, // transmit pin enable
	output logic transmit_pin_latch, // transmit port latch
	output logic boot_loader_mode, // loader mode active
	output logic watchdog_disable, // watchdog held off
	output logic [15:0] context_pointer, // forced register bank base
	output logic [15:0] stack_pointer, // forced stack pointer
	output logic [15:0] serial_control_register, // serial control
	output logic [15:0] system_config_register, // system config
	output logic [15:0] stack_underflow_limit, // stack underflow limit
	output logic [15:0] stack_overflow_limit, // stack overflow limit
	output logic [15:0] first_bus_config, // first bus config
	output logic [15:0] baud_reload_value, // measured reload
	output logic rx_enable, // serial receiver enabled
	output logic ram_wr_valid, // byte for internal ram
	output logic [15:0] ram_wr_addr, // ram byte address
	output logic [7:0] ram_wr_data, // ram byte
	output logic jump_request, // start loaded code
	output logic [15:0] jump_addr, // start address of loaded code
	output logic sel_boot_rom, // access served by boot rom
	output logic sel_flash, // access served by user flash
	output logic sel_external, // access goes off chip
	output logic sel_undefined // access returns undefined data
);
	// =====================================================
	// pin synchronisers
	logic [17:0] pin_s1, pin_s2;
	logic rx_s1, rx_s2, rx_d;
	logic [1:0] init_cnt;
	logic strap_low, ext_lat;
	logic [15:0] startup_lat;
	sbl_state_e state;
	logic [1:0] pre_cnt;
	logic [15:0] timer, div_rem, div_q;
	logic meas_ovf, overrun, flash_seg1, sw_reset;
	logic [20:0] bit_period;
	logic id_valid;
	logic rx_busy, rx_pend;
	logic [3:0] rx_bit;
	logic [20:0] rx_cnt;
	logic [7:0] rx_shift, rx_byte;
	logic [5:0] load_cnt;
	logic tx_busy;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_d <= 1'b1;
		end else begin
			pin_s1 <= {startup_cfg, external_access_strap, boot_select_strap};
			pin_s2 <= pin_s1;
			rx_s1 <= serial_receive_line;
			rx_s2 <= rx_s1;
			rx_d <= rx_s2;
		end
	end

	wire strap_take = (init_cnt == STRAP_SYNC) & (state == ST_INIT);
	wire rx_fall = rx_d & ~rx_s2;
	wire rx_rise = ~rx_d & rx_s2;
	wire enter = strap_take & ~pin_s2[0];
	wire leave = (strap_take & pin_s2[0]) | sw_reset;

	// =====================================================
	// strap capture, after release so no port feeds the reset value
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			init_cnt <= '0;
			strap_low <= 1'b0;
			ext_lat <= 1'b1;
			startup_lat <= '0;
		end else if (state == ST_INIT) begin
			init_cnt <= init_cnt + 2'h1;
			if (strap_take) begin
				strap_low <= ~pin_s2[0];
				ext_lat <= pin_s2[1];
				startup_lat <= pin_s2[17:2];
			end
		end
	end

	// =====================================================
	// register port
	wire wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
	wire [15:0] status_word = {boot_loader_mode, meas_ovf, overrun, rx_enable,
		jump_request, 1'b0, state, load_cnt};
	wire [15:0] rd_mux = (reg_addr == REG_STATUS) ? status_word :
		(reg_addr == REG_CTRL) ? {15'h0000, flash_seg1} :
		(reg_addr == REG_BAUD) ? baud_reload_value : 16'h0000;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
			flash_seg1 <= 1'b0;
			sw_reset <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
			sw_reset <= wr_ctrl & reg_wdata[CTRL_SWRST];
			if (wr_ctrl) begin
				flash_seg1 <= reg_wdata[CTRL_SEG1];
			end
		end
	end

	// =====================================================
	// loader sequence
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_INIT;
			pre_cnt <= '0;
			timer <= '0;
			div_rem <= '0;
			div_q <= '0;
			meas_ovf <= 1'b0;
			id_valid <= 1'b0;
			jump_request <= 1'b0;
		end else if (leave) begin
			state <= ST_NORMAL;
			id_valid <= 1'b0;
			jump_request <= 1'b0;
		end else begin
			case (state)
				ST_INIT: begin
					if (enter) begin
						state <= ST_WAIT_START;
					end
				end
				ST_WAIT_START: begin
					if (rx_fall) begin
						state <= ST_MEASURE;
						pre_cnt <= '0;
						timer <= '0;
					end
				end
				ST_MEASURE: begin
					pre_cnt <= pre_cnt + 2'h1;
					if (rx_rise) begin
						state <= ST_DIVIDE;
						div_q <= '0;
						div_rem <= (timer > CAL_OFFSET) ? timer - CAL_OFFSET : 16'h0000;
					end else if (pre_cnt == PRE_LAST) begin
						if (timer == 16'hFFFF) begin
							meas_ovf <= 1'b1;
							state <= ST_FAIL;
						end else begin
							timer <= timer + 16'h1;
						end
					end
				end
				ST_DIVIDE: begin
					if (div_rem >= CAL_STEP) begin
						div_rem <= div_rem - CAL_STEP;
						div_q <= div_q + 16'h1;
					end else begin
						state <= ST_SEND_ID;
						id_valid <= 1'b1;
					end
				end
				ST_SEND_ID: begin
					if (!tx_busy) begin
						id_valid <= 1'b0;
						state <= ST_WAIT_TX;
					end
				end
				ST_WAIT_TX: begin
					if (!tx_busy && !id_valid) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (load_cnt == LOAD_BYTES && !ram_wr_valid) begin
						state <= ST_RUN;
						jump_request <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// =====================================================
	// forced configuration and baud outputs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			boot_loader_mode <= 1'b0;
			watchdog_disable <= 1'b0;
			context_pointer <= CFG_NORMAL;
			stack_pointer <= CFG_NORMAL;
			serial_control_register <= CFG_NORMAL;
			system_config_register <= CFG_NORMAL;
			stack_underflow_limit <= CFG_NORMAL;
			stack_overflow_limit <= CFG_NORMAL;
			first_bus_config <= CFG_NORMAL;
			baud_reload_value <= '0;
			bit_period <= '0;
			transmit_pin_latch <= 1'b0;
			transmit_pin_direction <= 1'b0;
			rx_enable <= 1'b0;
			jump_addr <= '0;
		end else begin
			watchdog_disable <= boot_loader_mode;
			if (enter) begin
				boot_loader_mode <= 1'b1;
				context_pointer <= CTX_PTR_BOOT;
				stack_pointer <= STACK_PTR_BOOT;
				serial_control_register <= SCON_BOOT;
				system_config_register <= SYSCFG_BOOT;
				stack_underflow_limit <= STACK_UNDER_BOOT;
				stack_overflow_limit <= STACK_OVER_BOOT;
				first_bus_config <= pin_s2[17:2];
				jump_addr <= LOAD_BASE;
			end else if (leave) begin
				boot_loader_mode <= 1'b0;
				transmit_pin_latch <= 1'b0;
				transmit_pin_direction <= 1'b0;
				rx_enable <= 1'b0;
				// latch is still being loaded in the strap cycle itself
				first_bus_config <= strap_take ? pin_s2[17:2] : startup_lat;
			end else if (state == ST_DIVIDE && div_rem < CAL_STEP) begin
				baud_reload_value <= div_q;
				bit_period <= {16'(div_q + 16'h1), OVS_ZERO};
				transmit_pin_latch <= 1'b1;
				transmit_pin_direction <= 1'b1;
			end else if (state == ST_WAIT_TX && !tx_busy && !id_valid) begin
				rx_enable <= 1'b1;
			end
		end
	end

	// =====================================================
	// receiver: samples mid-bit at the measured rate
	wire rx_done = rx_busy & (rx_cnt == '0) & (rx_bit == RX_STOP);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rx_busy <= 1'b0;
			rx_bit <= '0;
			rx_cnt <= '0;
			rx_shift <= '0;
		end else if (!rx_busy) begin
			if (rx_enable && rx_fall && state == ST_LOAD) begin
				rx_busy <= 1'b1;
				rx_bit <= '0;
				rx_cnt <= {1'b0, bit_period[20:1]};
			end
		end else if (rx_cnt != '0) begin
			rx_cnt <= rx_cnt - 21'h1;
		end else begin
			rx_cnt <= bit_period - 21'h1;
			rx_bit <= rx_bit + 4'h1;
			if (rx_bit == '0 && rx_s2) begin
				rx_busy <= 1'b0; // false start, glitch
			end else if (rx_bit == RX_STOP) begin
				rx_busy <= 1'b0;
			end else if (rx_bit != '0) begin
				rx_shift <= {rx_s2, rx_shift[7:1]};
			end
		end
	end

	// =====================================================
	// byte path into internal ram
	sbl_stream_if #(.W(8)) rx_st();
	sbl_stream_if #(.W(8)) ram_st();
	sbl_stream_if #(.W(8)) tx_st();

	assign rx_st.valid = rx_pend;
	assign rx_st.data = rx_byte;
	assign ram_st.ready = ram_wr_ready;
	assign ram_wr_valid = ram_st.valid;
	assign ram_wr_data = ram_st.data;
	assign tx_st.valid = id_valid;
	assign tx_st.data = DEVICE_ID;

	// pending byte waits for buffer room; line itself cannot stall
	wire rx_take = rx_pend & rx_st.ready;
	wire room = load_cnt != LOAD_BYTES;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rx_pend <= 1'b0;
			rx_byte <= '0;
			overrun <= 1'b0;
			load_cnt <= '0;
			ram_wr_addr <= LOAD_BASE;
		end else begin
			if (rx_done && room && (!rx_pend || rx_take)) begin
				rx_pend <= 1'b1;
				rx_byte <= rx_shift;
			end else if (rx_take) begin
				rx_pend <= 1'b0;
			end
			if (rx_done && rx_pend && !rx_take) begin
				overrun <= 1'b1;
			end
			if (rx_take) begin
				load_cnt <= load_cnt + 6'h01;
			end
			if (ram_st.valid && ram_wr_ready && ram_wr_addr != LOAD_LAST) begin
				ram_wr_addr <= ram_wr_addr + 16'h0001;
			end
		end
	end

	sbl_skid_buf #(.W(8)) u_buf (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.in_s(rx_st),
		.out_s(ram_st)
	);

	sbl_uart_tx u_tx (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.bit_period(bit_period),
		.tx_s(tx_st),
		.tx_line(serial_transmit_pin),
		.busy(tx_busy)
	);

	// =====================================================
	// memory routing of the flash window
	wire [7:0] flash_seg = flash_seg1 ? FLASH_SEG1 : FLASH_SEG0;
	wire in_flash = (mem_addr[23:16] == flash_seg) & ~mem_addr[15];
	wire to_rom = boot_loader_mode & in_flash & mem_fetch;
	wire to_undef = boot_loader_mode & in_flash & ~mem_fetch & ~HAS_FLASH;
	wire to_ext = in_flash & ~boot_loader_mode & ~ext_lat;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sel_boot_rom <= 1'b0;
			sel_flash <= 1'b0;
			sel_external <= 1'b0;
			sel_undefined <= 1'b0;
		end else begin
			sel_boot_rom <= to_rom;
			sel_undefined <= to_undef;
			sel_external <= to_ext;
			sel_flash <= in_flash & ~to_rom & ~to_undef & ~to_ext;
		end
	end

	// =====================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	AST_ENTRY: assert property (enter |=> boot_loader_mode && state == ST_WAIT_START)
		else $error("strap low did not enter loader mode");
	AST_CAL_START: assert property (state == ST_WAIT_START && rx_fall && !leave
		|=> state == ST_MEASURE && timer == 16'h0000)
		else $error("calibration start missed");
	AST_BAUD: assert property (state == ST_DIVIDE && div_rem < CAL_STEP && !leave
		|=> baud_reload_value == $past(div_q) && state == ST_SEND_ID)
		else $error("baud reload not loaded");
	AST_TX_PIN: assert property (state == ST_SEND_ID |-> transmit_pin_latch
		&& transmit_pin_direction)
		else $error("transmit pin not driven before id byte");
	AST_ID: assert property ($fell(tx_busy) && state == ST_WAIT_TX |-> $past(serial_transmit_pin))
		else $error("id byte stop bit missing");
	AST_WDT: assert property (boot_loader_mode [*2] |-> watchdog_disable)
		else $error("watchdog enabled in loader mode");
	AST_CFG: assert property (enter |=> context_pointer == CTX_PTR_BOOT
		&& stack_pointer == STACK_PTR_BOOT
		&& serial_control_register == SCON_BOOT)
		else $error("entry pointers wrong");
	AST_SYS: assert property (enter |=> system_config_register == SYSCFG_BOOT
		&& stack_underflow_limit == STACK_UNDER_BOOT
		&& stack_overflow_limit == STACK_OVER_BOOT)
		else $error("entry system config wrong");
	AST_BUS: assert property (enter |=> first_bus_config == $past(pin_s2[17:2]))
		else $error("bus config not from start-up pins");
	AST_RX_EN: assert property (state == ST_LOAD |-> rx_enable)
		else $error("receiver off while loading");
	AST_EA: assert property (boot_loader_mode && in_flash |=> !sel_external)
		else $error("external strap honoured in loader mode");
	AST_FETCH: assert property (boot_loader_mode && in_flash && mem_fetch
		|=> sel_boot_rom && !sel_flash)
		else $error("code fetch reached flash");
	AST_UNDEF: assert property (boot_loader_mode && in_flash && !mem_fetch
		|=> sel_undefined == !HAS_FLASH && sel_flash == HAS_FLASH)
		else $error("flash data read routed wrongly");
	AST_JUMP: assert property (jump_request |-> load_cnt == LOAD_BYTES && jump_addr == LOAD_BASE)
		else $error("jump before 32 bytes stored");
	AST_OVF: assert property (meas_ovf |-> !id_valid && state != ST_SEND_ID)
		else $error("id byte sent after overflow");
	COV_BOOT: cover property (enter ##[1:1000] state == ST_SEND_ID);
	COV_FAIL: cover property (state == ST_MEASURE ##1 state == ST_FAIL);
	COV_JUMP: cover property ($rose(jump_request));
	COV_STALL: cover property (ram_wr_valid && !ram_wr_ready ##1 !rx_st.ready);
endmodule
`default_nettype wire

/* sbl_pkg.sv */
// Purpose: shared constants and types of the serial boot loader
// Assumes: single clock domain, 16-bit core configuration words
// Notes:   reload arithmetic uses a prescaled 16-bit measuring timer
package sbl_pkg;
	// =====================================================
	// entry configuration forced in boot-loader mode
	localparam logic [15:0] CTX_PTR_BOOT = 16'hFA00;
	localparam logic [15:0] STACK_PTR_BOOT = 16'hFA40;
	localparam logic [15:0] SCON_BOOT = 16'h8011;
	localparam logic [15:0] SYSCFG_BOOT = 16'h0E00;
	localparam logic [15:0] STACK_UNDER_BOOT = 16'hFA40;
	localparam logic [15:0] STACK_OVER_BOOT = 16'hFA0C;
	localparam logic [15:0] CFG_NORMAL = 16'h0000;
	// =====================================================
	// start-up code load
	localparam logic [15:0] LOAD_BASE = 16'hFA40;
	localparam logic [15:0] LOAD_LAST = 16'hFA5F;
	localparam logic [5:0] LOAD_BYTES = 6'h20;
	// =====================================================
	// calibration byte measurement
	localparam logic [15:0] CAL_OFFSET = 16'h0024;
	localparam logic [15:0] CAL_STEP = 16'h0048;
	localparam logic [1:0] PRE_LAST = 2'h3;
	localparam logic [4:0] OVS_ZERO = 5'h00;
	localparam logic [1:0] STRAP_SYNC = 2'h2;
	localparam logic [3:0] RX_STOP = 4'h9;
	localparam logic [3:0] TX_BITS = 4'h9;
	// =====================================================
	// flash window and register port
	localparam logic [7:0] FLASH_SEG0 = 8'h00;
	localparam logic [7:0] FLASH_SEG1 = 8'h01;
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_CTRL = 2'h1;
	localparam logic [1:0] REG_BAUD = 2'h2;
	localparam int CTRL_SEG1 = 0;
	localparam int CTRL_SWRST = 1;

	typedef enum logic [3:0] {
		ST_INIT = 4'h0,
		ST_NORMAL = 4'h1,
		ST_WAIT_START = 4'h2,
		ST_MEASURE = 4'h3,
		ST_DIVIDE = 4'h4,
		ST_SEND_ID = 4'h5,
		ST_WAIT_TX = 4'h6,
		ST_LOAD = 4'h7,
		ST_RUN = 4'h8,
		ST_FAIL = 4'h9
	} sbl_state_e;
endpackage

/* sbl_stream_if.sv */
// Purpose: valid/ready byte stream between loader modules
// Assumes: transfer when valid and ready are both high
// Notes:   source holds data stable until taken
`timescale 1ns/1ps
`default_nettype none
interface sbl_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

/* sbl_skid_buf.sv */
// Purpose: two-entry buffer in the received-byte path
// Assumes: sink may stall for any time
// Notes:   ready drops only when both entries are full
`timescale 1ns/1ps
`default_nettype none
module sbl_skid_buf
	import sbl_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic sys_clk, // core clock
	input wire logic resetn, // async reset, low
	sbl_stream_if.snk in_s, // from receiver
	sbl_stream_if.src out_s // towards ram port
);
	logic [W-1:0] d0, d1;
	logic vld0, vld1;
	wire push = in_s.valid & in_s.ready;
	wire pop = vld0 & out_s.ready;

	assign in_s.ready = ~vld1;
	assign out_s.valid = vld0;
	assign out_s.data = d0;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			d0 <= '0;
			d1 <= '0;
			vld0 <= 1'b0;
			vld1 <= 1'b0;
		end else if (pop) begin
			if (vld1) begin
				d0 <= d1;
				vld1 <= 1'b0;
			end else begin
				d0 <= in_s.data;
				vld0 <= push;
			end
		end else if (push) begin
			if (!vld0) begin
				d0 <= in_s.data;
				vld0 <= 1'b1;
			end else begin
				d1 <= in_s.data;
				vld1 <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* sbl_uart_tx.sv */
// Purpose: 8N1 transmitter with a runtime bit period
// Assumes: bit period stable while a byte is sent
// Notes:   line idles high, start bit driven on accept
`timescale 1ns/1ps
`default_nettype none
module sbl_uart_tx
	import sbl_pkg::*;
(
	input wire logic sys_clk, // core clock
	input wire logic resetn, // async reset, low
	input wire logic [20:0] bit_period, // clocks per bit
	sbl_stream_if.snk tx_s, // byte to send
	output logic tx_line, // serial output level
	output logic busy // byte in flight
);
	logic [8:0] shift;
	logic [3:0] bits;
	logic [20:0] cnt;

	assign tx_s.ready = ~busy;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_line <= 1'b1;
			busy <= 1'b0;
			shift <= '0;
			bits <= '0;
			cnt <= '0;
		end else if (!busy) begin
			if (tx_s.valid) begin
				tx_line <= 1'b0;
				shift <= {1'b1, tx_s.data};
				bits <= TX_BITS;
				busy <= 1'b1;
				cnt <= bit_period - 21'h1;
			end
		end else if (cnt != '0) begin
			cnt <= cnt - 21'h1;
		end else if (bits != '0) begin
			tx_line <= shift[0];
			shift <= {1'b0, shift[8:1]};
			bits <= bits - 4'h1;
			cnt <= bit_period - 21'h1;
		end else begin
			busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* sbl_host_model.sv */
// Purpose: host end of the boot serial link
// Assumes: bit times counted in sys_clk cycles
// Notes:   receive line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module sbl_host_model (
	input wire logic sys_clk, // core clock
	input wire logic tx_line, // device transmit pin
	output logic rx_line // device receive pin
);
	initial rx_line = 1'b1;
	// ========
	// 8N1 frames, lsb first
	task automatic send(input logic [7:0] b, input int per);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			rx_line <= f[i];
			repeat (per - 1) @(posedge sys_clk);
		end
	endtask
	// sample mid bit, so a small rate error still reads clean
	task automatic recv(output logic [7:0] b, input int per);
		int n;
		n = 0;
		while (tx_line !== 1'b0 && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (per / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (per) @(posedge sys_clk);
			b[i] = tx_line;
		end
		repeat (per) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

/* test_sbl_boot_loader.sv */
// Purpose: self-checking bench of the serial boot loader
// Assumes: host bit time 64 clocks, reload 1
// Notes:   reads and ram writes checked from queues
`timescale 1ns/1ps
`default_nettype none
module test_sbl_boot_loader
	import sbl_pkg::*;
;
	localparam logic [7:0] ID_ARB = 8'h3C; // arbitrary value
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic boot_select_strap = 1'b0;
	logic external_access_strap = 1'b0;
	logic [15:0] startup_cfg = 16'h0000;
	logic serial_receive_line;
	logic [23:0] mem_addr = 24'h000000;
	logic mem_fetch = 1'b0;
	logic ram_wr_ready = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic [15:0] reg_rdata, context_pointer, stack_pointer, serial_control_register;
	logic [15:0] system_config_register, stack_underflow_limit, stack_overflow_limit;
	logic [15:0] first_bus_config, baud_reload_value, ram_wr_addr, jump_addr;
	logic serial_transmit_pin, transmit_pin_direction, transmit_pin_latch;
	logic boot_loader_mode, watchdog_disable, rx_enable, ram_wr_valid, jump_request;
	logic sel_boot_rom, sel_flash, sel_external, sel_undefined;
	logic [7:0] ram_wr_data, id, b;
	logic [23:0] rd_q[$];
	logic [23:0] wr_q[$];
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	always #20 sys_clk = ~sys_clk;
	sbl_boot_loader #(.DEVICE_ID(ID_ARB), .HAS_FLASH(1'b1)) dut (
		.sys_clk, .resetn, .boot_select_strap, .external_access_strap, .startup_cfg,
		.serial_receive_line, .mem_addr, .mem_fetch, .ram_wr_ready, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_transmit_pin,
		.transmit_pin_direction, .transmit_pin_latch, .boot_loader_mode,
		.watchdog_disable, .context_pointer, .stack_pointer, .serial_control_register,
		.system_config_register, .stack_underflow_limit, .stack_overflow_limit,
		.first_bus_config, .baud_reload_value, .rx_enable, .ram_wr_valid, .ram_wr_addr,
		.ram_wr_data, .jump_request, .jump_addr, .sel_boot_rom, .sel_flash,
		.sel_external, .sel_undefined);
	sbl_host_model host (.sys_clk, .tx_line(serial_transmit_pin), .rx_line(serial_receive_line));
	// ========
	// tasks
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hw_reset(input logic strap);
		@(posedge sys_clk);
		resetn <= 1'b0;
		boot_select_strap <= strap;
		startup_cfg <= 16'($urandom);
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		rd_q.push_back(24'(e));
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic route(input logic [23:0] a, input logic f, input logic [3:0] e);
		@(posedge sys_clk);
		mem_addr <= a;
		mem_fetch <= f;
		repeat (2) @(posedge sys_clk);
		#1 chk(24'({sel_boot_rom, sel_flash, sel_external, sel_undefined}), 24'(e));
	endtask
	// ========
	// result watcher, ram stalls at random
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		if (rd_d) chk(24'(reg_rdata), rd_q.pop_front());
		if (ram_wr_valid && ram_wr_ready) chk({ram_wr_addr, ram_wr_data}, wr_q.pop_front());
		ram_wr_ready <= ($urandom % 4) != 0;
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			conclude();
		end
	end
	// ========
	// main sequence
	initial begin
		void'($urandom(32'h738ED5E6));
		hw_reset(1'b0);
		chk(24'(boot_loader_mode), 24'h1);
		chk(24'(watchdog_disable), 24'h1);
		chk(24'(context_pointer), 24'hFA00);
		chk(24'(stack_pointer), 24'hFA40);
		chk(24'(serial_control_register), 24'h8011);
		chk(24'(system_config_register), 24'h0E00);
		chk(24'(stack_underflow_limit), 24'hFA40);
		chk(24'(stack_overflow_limit), 24'hFA0C);
		chk(24'(first_bus_config), 24'(startup_cfg));
		chk(24'({transmit_pin_direction, rx_enable}), 24'h0);
		route(24'h001000, 1'b1, 4'h8);
		route(24'h001000, 1'b0, 4'h4);
		wr(REG_CTRL, 16'h0001);
		rd(REG_CTRL, 16'h0001);
		rd(2'h3, 16'h0000);
		route(24'h011000, 1'b1, 4'h8);
		route(24'h001000, 1'b1, 4'h0);
		wr(REG_CTRL, 16'h0000);
		fork
			host.send(8'h00, 64);
			host.recv(id, 64);
		join
		chk(24'(id), 24'(ID_ARB));
		chk(24'(baud_reload_value), 24'h1);
		rd(REG_BAUD, 16'h0001);
		chk(24'({transmit_pin_latch, transmit_pin_direction}), 24'h3);
		for (int i = 0; i < 300 && rx_enable !== 1'b1; i++) @(posedge sys_clk);
		chk(24'(rx_enable), 24'h1);
		for (int i = 0; i < 33; i++) begin
			b = 8'($urandom);
			if (i < 32) wr_q.push_back({16'hFA40 + 16'(i), b});
			host.send(b, 64);
		end
		for (int i = 0; i < 300 && jump_request !== 1'b1; i++) @(posedge sys_clk);
		chk(24'({jump_request, jump_addr}), 24'h1FA40);
		chk(24'(wr_q.size()), 24'h0);
		// status: mode, receiver on, jump, state run, 32 bytes taken
		rd(REG_STATUS, 16'h9A20);
		// loaded code only reads data from the flash window, never fetches
		route(24'h001000, 1'b0, 4'h4);
		wr(REG_CTRL, 16'h0002);
		repeat (4) @(posedge sys_clk);
		chk(24'({boot_loader_mode, watchdog_disable}), 24'h0);
		hw_reset(1'b1);
		chk(24'(boot_loader_mode), 24'h0);
		chk(24'(system_config_register), 24'h0000);
		route(24'h001000, 1'b0, 4'h2);
		conclude();
	end
endmodule
`default_nettype wire
